//--- rtl/clock_ctrl_pkg.sv
package clock_ctrl_pkg;

	localparam logic [7:0] SRC_SEL_OFS    = 8'h00;
	localparam logic [7:0] PRESCALE_OFS   = 8'h01;
	localparam logic [7:0] FREEZE_OFS     = 8'h02;
	localparam logic [7:0] STATUS_OFS     = 8'h03;
	localparam logic [7:0] FAST_CTRL_OFS  = 8'h10;
	localparam logic [7:0] FAST_TRIM_OFS  = 8'h11;
	localparam logic [7:0] FAST_SLOPE_OFS = 8'h12;
	localparam logic [7:0] SLOW_CTRL_OFS  = 8'h18;
	localparam logic [7:0] UNLOCK_OFS     = 8'h20;

	localparam logic [7:0] UNLOCK_KEY     = 8'hA5;
	localparam logic [2:0] UNLOCK_WINDOW  = 3'h4;

	localparam logic [1:0] SRC_FAST       = 2'h0;
	localparam logic [1:0] SRC_SLOW       = 2'h1;
	localparam logic [1:0] SRC_RESERVED   = 2'h2;
	localparam logic [1:0] SRC_EXT        = 2'h3;

	localparam logic [7:0] SRC_SEL_RESET  = 8'h00;
	localparam logic [7:0] PRESCALE_RESET = 8'h11;

	localparam int         SYSCLK_PIN_DRIVE_BIT     = 7;
	localparam int         KEEP_BIT       = 1;
	localparam int         PEN_BIT        = 0;
	localparam int         FREEZE_BIT     = 0;

	localparam logic [2:0] OSC_GATE_EDGES = 3'h4;
	localparam logic [2:0] EXT_GATE_EDGES = 3'h2;

	localparam logic [1:0] FREQ_CHOICE_16 = 2'h1;
	localparam logic [5:0] TRIM_16M_RESET = 6'h1F;
	localparam logic [5:0] TRIM_20M_RESET = 6'h20;
	localparam logic [3:0] SLOPE_16M_RESET = 4'h7;
	localparam logic [3:0] SLOPE_20M_RESET = 4'h8;

	typedef enum logic [1:0] {
		SW_IDLE = 2'b01,
		SW_PEND = 2'b10
	} switch_state_e;

endpackage

//--- rtl/main_clock_select_prescale.sv
// How it works
// - Select field: 0 fast, 1 slow, 3 external.
// - Ratio codes give 2..64 and 6..48 division.
// - Ratio field writable while running.
// - Prescaler off passes main clock undivided.
// - Freeze blocks both main control registers; calibration only while fast is active.
// - Freeze register stays shut until reset.
// - Freeze bit loaded from fuse at reset.
// - External started flag is read-only status.
// - Stable flag needs request and stable oscillator.
// - Switching flag high until new source stable.
// - Keep-running bit keeps oscillator powered always.
// - Kept-running unrequested oscillator gives no clock.
// - Oscillator gates open after four cycles; keep skips analog.
// - Trim field loaded from fuse frequency choice.
// - Trim-frozen bit blocks both calibration registers.
// - Slope field loaded from fuse frequency choice.
// - Protected writes need key within four cycles.
// - Clock-out bit drives system clock to pin.
// - External clock usable two cycles after request.
module main_clock_select_prescale
	import clock_ctrl_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       srst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rd_data_o,
	input  wire logic       fast_osc_clk_i,
	input  wire logic       slow_osc_clk_i,
	input  wire logic       external_clock_input_i,
	input  wire logic       fast_osc_ready_i,
	input  wire logic       slow_osc_ready_i,
	input  wire logic [2:0] periph_req_i,
	input  wire logic       trim_freeze_fuse_bit_i,
	input  wire logic [1:0] frequency_choice_i,
	output logic            peripheral_clock_o,
	output logic            sysclk_pin_drive_o,
	output logic            fast_osc_power_o,
	output logic            slow_osc_power_o,
	output logic            ext_pin_claim_o,
	output logic      [5:0] fast_osc_trim_value_o,
	output logic      [3:0] temperature_slope_o
);

	function automatic logic [1:0] src_idx(input logic [1:0] code);
		src_idx = (code == SRC_EXT) ? 2'd2 : code;
	endfunction

	function automatic logic [5:0] div_half(input logic [3:0] code);
		case (code)
			4'h0:    div_half = 6'd1;
			4'h1:    div_half = 6'd2;
			4'h2:    div_half = 6'd4;
			4'h3:    div_half = 6'd8;
			4'h4:    div_half = 6'd16;
			4'h5:    div_half = 6'd32;
			4'h8:    div_half = 6'd3;
			4'h9:    div_half = 6'd5;
			4'hA:    div_half = 6'd6;
			4'hB:    div_half = 6'd12;
			4'hC:    div_half = 6'd24;
			default: div_half = 6'd1;
		endcase
	endfunction

	logic [2:0] clk_s1_reg;
	logic [2:0] clk_s2_reg;
	logic [2:0] clk_s3_reg;
	logic [1:0] rdy_s1_reg;
	logic [1:0] rdy_s2_reg;
	logic [2:0] fuse_s1_reg;
	logic [2:0] fuse_s2_reg;

	logic [1:0]    sel_reg;
	logic          sysclk_pin_drive_reg;
	logic [3:0]    ratio_reg;
	logic          pen_reg;
	logic          freeze_reg;
	logic [1:0]    keep_reg;
	logic [5:0]    trim_reg;
	logic [3:0]    slope_reg;
	logic          trimlock_reg;
	logic [1:0]    active_reg;
	switch_state_e state_reg;
	switch_state_e state_next;
	logic [2:0]    win_reg;
	logic [2:0]    gate_cnt_reg [3];
	logic [5:0]    div_cnt_reg;
	logic [5:0]    div_cnt_next;
	logic          per_reg;
	logic          per_next;
	logic          pin_reg;
	logic [1:0]    power_reg;
	logic          claim_reg;
	logic [7:0]    rd_data_reg;

	wire logic [2:0] edge_w  = clk_s2_reg & ~clk_s3_reg;
	wire logic [1:0] sel_i   = src_idx(sel_reg);
	wire logic [1:0] act_i   = src_idx(active_reg);
	wire logic       unlocked = (win_reg != 3'd0);
	wire logic       wr_ok   = wr_i & unlocked;
	wire logic       main_wr = wr_ok & ~freeze_reg;
	wire logic       cal_lock = trimlock_reg | (freeze_reg & (active_reg == SRC_FAST));
	wire logic       cal_wr  = wr_ok & ~cal_lock;
	wire logic       key_wr  = wr_i & (addr_i == UNLOCK_OFS) & (wr_data_i == UNLOCK_KEY);
	wire logic       sel_wr  = main_wr & (addr_i == SRC_SEL_OFS)
		& (wr_data_i[1:0] != SRC_RESERVED);
	wire logic       pre_wr  = main_wr & (addr_i == PRESCALE_OFS);
	wire logic       frz_wr  = main_wr & (addr_i == FREEZE_OFS) & wr_data_i[FREEZE_BIT];
	wire logic       fk_wr   = wr_ok & (addr_i == FAST_CTRL_OFS);
	wire logic       sk_wr   = wr_ok & (addr_i == SLOW_CTRL_OFS);
	wire logic       trim_wr = cal_wr & (addr_i == FAST_TRIM_OFS);
	wire logic       slope_wr = cal_wr & (addr_i == FAST_SLOPE_OFS);

	logic [2:0] req_w;
	logic [2:0] can_w;
	logic [2:0] gate_open_w;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			req_w[i] = (sel_i == 2'(i)) | (act_i == 2'(i)) | periph_req_i[i];
			gate_open_w[i] = req_w[i] & (gate_cnt_reg[i] ==
				((i == 2) ? EXT_GATE_EDGES : OSC_GATE_EDGES));
		end
		can_w = {1'b1, rdy_s2_reg | keep_reg};
	end

	wire logic main_lvl  = clk_s2_reg[act_i] & gate_open_w[act_i];
	wire logic main_edge = edge_w[act_i] & gate_open_w[act_i];
	wire logic pending   = (state_reg == SW_PEND);
	wire logic can_swap  = gate_open_w[sel_i] & ~clk_s2_reg[sel_i]
		& ~clk_s2_reg[act_i];
	wire logic [5:0] half_w = div_half(ratio_reg);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SW_IDLE: begin
				if (sel_reg != active_reg) begin
					state_next = SW_PEND;
				end
			end
			SW_PEND: begin
				if (sel_reg == active_reg || can_swap) begin
					state_next = SW_IDLE;
				end
			end
			default: state_next = SW_IDLE;
		endcase
	end

	always_comb begin
		div_cnt_next = div_cnt_reg;
		per_next = per_reg;
		if (!pen_reg) begin
			div_cnt_next = 6'd0;
			per_next = main_lvl;
		end else if (main_edge) begin
			if (div_cnt_reg + 6'd1 >= half_w) begin
				div_cnt_next = 6'd0;
				per_next = ~per_reg;
			end else begin
				div_cnt_next = div_cnt_reg + 6'd1;
			end
		end
	end

	logic [7:0] rd_mux;
	always_comb begin
		case (addr_i)
			SRC_SEL_OFS:    rd_mux = {sysclk_pin_drive_reg, 5'd0, sel_reg};
			PRESCALE_OFS:   rd_mux = {3'd0, ratio_reg, pen_reg};
			FREEZE_OFS:     rd_mux = {7'd0, freeze_reg};
			STATUS_OFS:     rd_mux = {gate_open_w[2], 1'b0, gate_open_w[1:0],
				3'd0, pending};
			FAST_CTRL_OFS:  rd_mux = {6'd0, keep_reg[0], 1'b0};
			FAST_TRIM_OFS:  rd_mux = {2'd0, trim_reg};
			FAST_SLOPE_OFS: rd_mux = {trimlock_reg, 3'd0, slope_reg};
			SLOW_CTRL_OFS:  rd_mux = {6'd0, keep_reg[1], 1'b0};
			default:        rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		clk_s1_reg  <= {external_clock_input_i, slow_osc_clk_i, fast_osc_clk_i};
		clk_s2_reg  <= clk_s1_reg;
		clk_s3_reg  <= clk_s2_reg;
		rdy_s1_reg  <= {slow_osc_ready_i, fast_osc_ready_i};
		rdy_s2_reg  <= rdy_s1_reg;
		fuse_s1_reg <= {frequency_choice_i, trim_freeze_fuse_bit_i};
		fuse_s2_reg <= fuse_s1_reg;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sel_reg      <= SRC_SEL_RESET[1:0];
			sysclk_pin_drive_reg   <= SRC_SEL_RESET[SYSCLK_PIN_DRIVE_BIT];
			ratio_reg    <= PRESCALE_RESET[4:1];
			pen_reg      <= PRESCALE_RESET[PEN_BIT];
			freeze_reg   <= fuse_s2_reg[0];
			trimlock_reg <= fuse_s2_reg[0];
			keep_reg     <= 2'b00;
		end else begin
			if (sel_wr) begin
				sel_reg    <= wr_data_i[1:0];
				sysclk_pin_drive_reg <= wr_data_i[SYSCLK_PIN_DRIVE_BIT];
			end
			if (pre_wr) begin
				ratio_reg <= wr_data_i[4:1];
				pen_reg   <= wr_data_i[PEN_BIT];
			end
			if (frz_wr) begin
				freeze_reg <= 1'b1;
			end
			if (fk_wr) begin
				keep_reg[0] <= wr_data_i[KEEP_BIT];
			end
			if (sk_wr) begin
				keep_reg[1] <= wr_data_i[KEEP_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			trim_reg  <= (fuse_s2_reg[2:1] == FREQ_CHOICE_16) ?
				TRIM_16M_RESET : TRIM_20M_RESET;
			slope_reg <= (fuse_s2_reg[2:1] == FREQ_CHOICE_16) ?
				SLOPE_16M_RESET : SLOPE_20M_RESET;
		end else begin
			if (trim_wr) begin
				trim_reg <= wr_data_i[5:0];
			end
			if (slope_wr) begin
				slope_reg <= wr_data_i[3:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			win_reg <= 3'd0;
		end else if (key_wr) begin
			win_reg <= UNLOCK_WINDOW;
		end else if (unlocked) begin
			win_reg <= win_reg - 3'd1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (srst_i || !req_w[i]) begin
				gate_cnt_reg[i] <= 3'd0;
			end else if (can_w[i] && edge_w[i] && !gate_open_w[i]) begin
				gate_cnt_reg[i] <= gate_cnt_reg[i] + 3'd1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_reg  <= SW_IDLE;
			active_reg <= SRC_SEL_RESET[1:0];
		end else begin
			state_reg <= state_next;
			if (state_reg == SW_PEND && can_swap) begin
				active_reg <= sel_reg;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			div_cnt_reg <= 6'd0;
			per_reg     <= 1'b0;
			pin_reg     <= 1'b0;
			power_reg   <= 2'b00;
			claim_reg   <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			div_cnt_reg <= div_cnt_next;
			per_reg     <= per_next;
			pin_reg     <= sysclk_pin_drive_reg & main_lvl;
			power_reg   <= req_w[1:0] | keep_reg;
			claim_reg   <= req_w[2];
			rd_data_reg <= rd_i ? rd_mux : 8'h00;
		end
	end

	assign rd_data_o             = rd_data_reg;
	assign peripheral_clock_o    = per_reg;
	assign sysclk_pin_drive_o    = pin_reg;
	assign fast_osc_power_o      = power_reg[0];
	assign slow_osc_power_o      = power_reg[1];
	assign ext_pin_claim_o       = claim_reg;
	assign fast_osc_trim_value_o = trim_reg;
	assign temperature_slope_o   = slope_reg;

	property p_locked_write;
		@(posedge sys_clk_i) disable iff (srst_i)
		(wr_i && addr_i == PRESCALE_OFS && win_reg == 3'd0) |=> $stable({ratio_reg, pen_reg});
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("Write without key took effect.");

	property p_freeze_sticky;
		@(posedge sys_clk_i) disable iff (srst_i)
		freeze_reg |=> freeze_reg;
	endproperty
	a_freeze_sticky: assert property (p_freeze_sticky) else $error("Freeze bit cleared.");

	property p_freeze_blocks;
		@(posedge sys_clk_i) disable iff (srst_i)
		(freeze_reg && wr_i) |=> $stable({sel_reg, sysclk_pin_drive_reg, ratio_reg, pen_reg});
	endproperty
	a_freeze_blocks: assert property (p_freeze_blocks) else $error("Frozen register changed.");

	property p_reserved_sel;
		@(posedge sys_clk_i) disable iff (srst_i)
		(wr_ok && addr_i == SRC_SEL_OFS && wr_data_i[1:0] == SRC_RESERVED) |=> $stable(sel_reg);
	endproperty
	a_reserved_sel: assert property (p_reserved_sel) else $error("Reserved source taken.");

	property p_no_req_no_gate;
		@(posedge sys_clk_i) disable iff (srst_i)
		(!req_w[1] && keep_reg[1]) |=> gate_cnt_reg[1] == 3'd0;
	endproperty
	a_no_req_no_gate: assert property (p_no_req_no_gate) else $error("Idle gate open.");

	property p_gate_four;
		@(posedge sys_clk_i) disable iff (srst_i)
		$rose(gate_open_w[1]) |-> $past(gate_cnt_reg[1]) == 3'd3 && $past(edge_w[1]);
	endproperty
	a_gate_four: assert property (p_gate_four) else $error("Slow gate opened early.");

	property p_ext_two;
		@(posedge sys_clk_i) disable iff (srst_i)
		$rose(gate_open_w[2]) |-> $past(gate_cnt_reg[2]) == 3'd1;
	endproperty
	a_ext_two: assert property (p_ext_two) else $error("External gate timing wrong.");

	property p_pending;
		@(posedge sys_clk_i) disable iff (srst_i)
		pending |-> (sel_reg != active_reg) || $past(sel_reg) != sel_reg;
	endproperty
	a_pending: assert property (p_pending) else $error("Pending with no change.");

	property p_sysclk_pin_drive_off;
		@(posedge sys_clk_i) disable iff (srst_i)
		!sysclk_pin_drive_reg |=> !sysclk_pin_drive_o;
	endproperty
	a_sysclk_pin_drive_off: assert property (p_sysclk_pin_drive_off) else $error("Clock pin driven while off.");

	property p_trim_frozen;
		@(posedge sys_clk_i) disable iff (srst_i)
		(trimlock_reg && wr_i) |=> $stable({trim_reg, slope_reg});
	endproperty
	a_trim_frozen: assert property (p_trim_frozen) else $error("Frozen trim changed.");

	property p_bypass;
		@(posedge sys_clk_i) disable iff (srst_i)
		!pen_reg |=> peripheral_clock_o == $past(main_lvl);
	endproperty
	a_bypass: assert property (p_bypass) else $error("Bypassed clock differs.");

	property p_keep_power;
		@(posedge sys_clk_i) disable iff (srst_i)
		keep_reg[1] |=> slow_osc_power_o;
	endproperty
	a_keep_power: assert property (p_keep_power) else $error("Kept oscillator unpowered.");

endmodule

//--- verif/main_clock_select_prescale_test.sv
module main_clock_select_prescale_test
	import clock_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DV[11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
	localparam int CD[11] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12};
	logic        sys_clk_i;
	logic        srst_i                 = 1'b1;
	logic [7:0]  addr_i                 = 8'h00;
	logic [7:0]  wr_data_i              = 8'h00;
	logic        wr_i                   = 1'b0;
	logic        rd_i                   = 1'b0;
	logic [7:0]  rd_data_o;
	logic        fast_osc_clk_i         = 1'b0;
	logic        slow_osc_clk_i         = 1'b0;
	logic        external_clock_input_i = 1'b0;
	logic        fast_osc_ready_i       = 1'b1;
	logic        slow_osc_ready_i       = 1'b1;
	logic [2:0]  periph_req_i           = 3'h0;
	logic        trim_freeze_fuse_bit_i = 1'b0;
	logic [1:0]  frequency_choice_i     = 2'h0;
	logic        peripheral_clock_o;
	logic        sysclk_pin_drive_o;
	logic        fast_osc_power_o;
	logic        slow_osc_power_o;
	logic        ext_pin_claim_o;
	logic [5:0]  fast_osc_trim_value_o;
	logic [3:0]  temperature_slope_o;
	logic [7:0]  cyc                    = 8'h00;
	logic        rd_seen                = 1'b0;
	logic [7:0]  exp_q[$];
	logic [7:0]  trim;
	logic [3:0]  slope;
	int          fails                  = 0;
	int          tests_run              = 0;
	int          c;

	main_clock_select_prescale i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.fast_osc_clk_i(fast_osc_clk_i), .slow_osc_clk_i(slow_osc_clk_i),
		.external_clock_input_i(external_clock_input_i), .fast_osc_ready_i(fast_osc_ready_i),
		.slow_osc_ready_i(slow_osc_ready_i), .periph_req_i(periph_req_i),
		.trim_freeze_fuse_bit_i(trim_freeze_fuse_bit_i), .frequency_choice_i(frequency_choice_i),
		.peripheral_clock_o(peripheral_clock_o), .sysclk_pin_drive_o(sysclk_pin_drive_o),
		.fast_osc_power_o(fast_osc_power_o), .slow_osc_power_o(slow_osc_power_o),
		.ext_pin_claim_o(ext_pin_claim_o), .fast_osc_trim_value_o(fast_osc_trim_value_o),
		.temperature_slope_o(temperature_slope_o));

	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// Oscillator stand-ins: fast period 4, external 8, slow 16 system cycles.
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 8'h01;
		fast_osc_clk_i <= cyc[1];
		external_clock_input_i <= cyc[2];
		slow_osc_clk_i <= cyc[3];
		rd_seen <= rd_i;
	end

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask

	// The monitor takes the oldest noted read value when the read data stand.
	always @(negedge sys_clk_i) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0) begin
			check("rd_data_o", rd_data_o, exp_q.pop_front());
		end
	end

	task automatic do_reset();
		@(posedge sys_clk_i);
		srst_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic prot(input logic [7:0] a, input logic [7:0] d);
		wr(UNLOCK_OFS, UNLOCK_KEY);
		wr(a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input bit note);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		if (note) begin
			exp_q.push_back(exp);
		end
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(negedge sys_clk_i);
	endtask

	// Polls the status register until the masked bits match; fails and stops after 300 reads.
	task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
		int i;
		for (i = 0; i < 300; i++) begin
			rd(STATUS_OFS, 8'h00, 1'b0);
			if ((rd_data_o & m) === v) begin
				break;
			end
		end
		if (i == 300) begin
			fails++;
			stop_test();
		end
	endtask

	task automatic edges(input bit pin, input int e);
		logic p;
		logic cur;
		int   n;
		n = 0;
		p = 1'b1;
		repeat (960) begin
			@(negedge sys_clk_i);
			cur = pin ? sysclk_pin_drive_o : peripheral_clock_o;
			if (cur === 1'b1 && p !== 1'b1) begin
				n++;
			end
			p = cur;
		end
		check("clock_edges", {7'h00, (n >= e - 1 && n <= e + 1)}, 8'h01);
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk_i);
		fails++;
		stop_test();
	end

	initial begin
		void'($urandom(64));
		trim = $urandom & 8'h3F;
		slope = $urandom & 8'h0F;
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		rd(SRC_SEL_OFS, SRC_SEL_RESET, 1'b1);
		rd(PRESCALE_OFS, PRESCALE_RESET, 1'b1);
		rd(FREEZE_OFS, 8'h00, 1'b1);
		rd(FAST_TRIM_OFS, {2'h0, TRIM_20M_RESET}, 1'b1);
		rd(FAST_SLOPE_OFS, {4'h0, SLOPE_20M_RESET}, 1'b1);
		rd(8'h40, 8'h00, 1'b1);
		wait_stat(8'h10, 8'h10);
		rd(STATUS_OFS, 8'h10, 1'b1);
		check("fast_power", {7'h00, fast_osc_power_o}, 8'h01);
		wr(PRESCALE_OFS, 8'h03);
		rd(PRESCALE_OFS, PRESCALE_RESET, 1'b1);
		wr(UNLOCK_OFS, UNLOCK_KEY);
		repeat (5) @(posedge sys_clk_i);
		wr(PRESCALE_OFS, 8'h03);
		rd(PRESCALE_OFS, PRESCALE_RESET, 1'b1);
		wr(UNLOCK_OFS, UNLOCK_KEY);
		repeat (2) @(posedge sys_clk_i);
		wr(PRESCALE_OFS, 8'h05);
		rd(PRESCALE_OFS, 8'h05, 1'b1);
		for (int i = 0; i < 11; i++) begin
			prot(PRESCALE_OFS, {3'h0, CD[i][3:0], 1'b1});
			rd(PRESCALE_OFS, {3'h0, CD[i][3:0], 1'b1}, 1'b1);
			repeat (200) @(posedge sys_clk_i);
			edges(1'b0, 240 / DV[i]);
		end
		prot(PRESCALE_OFS, 8'h0A);
		repeat (50) @(posedge sys_clk_i);
		edges(1'b0, 240);
		prot(FAST_TRIM_OFS, {2'h0, trim[5:0]});
		prot(FAST_SLOPE_OFS, {4'h0, slope});
		rd(FAST_TRIM_OFS, {2'h0, trim[5:0]}, 1'b1);
		rd(FAST_SLOPE_OFS, {4'h0, slope}, 1'b1);
		check("trim_out", {2'h0, fast_osc_trim_value_o}, {2'h0, trim[5:0]});
		check("slope_out", {4'h0, temperature_slope_o}, {4'h0, slope});
		prot(SLOW_CTRL_OFS, 8'h02);
		rd(SLOW_CTRL_OFS, 8'h02, 1'b1);
		repeat (40) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		check("slow_power", {7'h00, slow_osc_power_o}, 8'h01);
		rd(STATUS_OFS, 8'h10, 1'b1);
		@(posedge sys_clk_i);
		periph_req_i <= 3'b010;
		wait_stat(8'h20, 8'h20);
		rd(STATUS_OFS, 8'h30, 1'b1);
		@(posedge sys_clk_i);
		periph_req_i <= 3'b000;
		prot(SLOW_CTRL_OFS, 8'h00);
		slow_osc_ready_i <= 1'b0;
		repeat (40) @(posedge sys_clk_i);
		prot(SRC_SEL_OFS, {6'h00, SRC_SLOW});
		repeat (100) @(posedge sys_clk_i);
		rd(STATUS_OFS, 8'h11, 1'b1);
		rd(SRC_SEL_OFS, {6'h00, SRC_SLOW}, 1'b1);
		@(posedge sys_clk_i);
		slow_osc_ready_i <= 1'b1;
		wait_stat(8'h21, 8'h20);
		rd(STATUS_OFS, 8'h20, 1'b1);
		check("fast_power", {7'h00, fast_osc_power_o}, 8'h00);
		edges(1'b0, 60);
		prot(SRC_SEL_OFS, {6'h00, SRC_RESERVED});
		rd(SRC_SEL_OFS, {6'h00, SRC_SLOW}, 1'b1);
		prot(SRC_SEL_OFS, {6'h00, SRC_EXT});
		wait_stat(8'h81, 8'h80);
		rd(STATUS_OFS, 8'h80, 1'b1);
		check("ext_claim", {7'h00, ext_pin_claim_o}, 8'h01);
		edges(1'b0, 120);
		prot(SRC_SEL_OFS, 8'h80);
		wait_stat(8'h11, 8'h10);
		edges(1'b1, 240);
		prot(FREEZE_OFS, 8'h01);
		rd(FREEZE_OFS, 8'h01, 1'b1);
		prot(PRESCALE_OFS, 8'h03);
		rd(PRESCALE_OFS, 8'h0A, 1'b1);
		prot(SRC_SEL_OFS, 8'h00);
		rd(SRC_SEL_OFS, 8'h80, 1'b1);
		prot(FAST_TRIM_OFS, {2'h0, ~trim[5:0]});
		rd(FAST_TRIM_OFS, {2'h0, trim[5:0]}, 1'b1);
		prot(FREEZE_OFS, 8'h00);
		rd(FREEZE_OFS, 8'h01, 1'b1);
		@(posedge sys_clk_i);
		trim_freeze_fuse_bit_i <= 1'b1;
		frequency_choice_i <= FREQ_CHOICE_16;
		do_reset();
		rd(FREEZE_OFS, 8'h01, 1'b1);
		rd(PRESCALE_OFS, PRESCALE_RESET, 1'b1);
		rd(FAST_SLOPE_OFS, {4'h8, SLOPE_16M_RESET}, 1'b1);
		prot(FAST_TRIM_OFS, {2'h0, ~TRIM_16M_RESET});
		prot(FAST_SLOPE_OFS, {4'h0, ~SLOPE_16M_RESET});
		rd(FAST_TRIM_OFS, {2'h0, TRIM_16M_RESET}, 1'b1);
		rd(FAST_SLOPE_OFS, {4'h8, SLOPE_16M_RESET}, 1'b1);
		repeat (3) @(posedge sys_clk_i);
		stop_test();
	end
endmodule
